// file: design/als_pkg.sv
// Purpose: constants and carriers for the alert summary status block
// Assumes: 16-bit register port, 4-bit word address
// Notes:   offsets are word indices on the plain register port
`default_nettype none
package als_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int AUX_N  = 6;
  localparam int CAL_N  = 5;
  localparam int CB_N   = 5;
  localparam int DIAG_W = 16;

  // register word offsets
  localparam logic [3:0] OFF_SUMMARY = 4'h0;
  localparam logic [3:0] OFF_IFERR   = 4'h1;
  localparam logic [3:0] OFF_SOURCE  = 4'h2;
  localparam logic [3:0] OFF_IRQEN   = 4'h3;
  localparam logic [3:0] OFF_CBSTAT  = 4'h4;
  localparam logic [3:0] OFF_CBCTRL  = 4'h5;
  localparam logic [3:0] OFF_EVENT   = 4'h6;
  localparam logic [3:0] OFF_EVMASK  = 4'h7;

  // summary register bit positions
  localparam int SUM_AUXOV = 8;
  localparam int SUM_AUXUV = 7;
  localparam int SUM_PEC   = 5;
  localparam int SUM_IFC   = 4;
  localparam int SUM_CAL   = 3;
  localparam int SUM_CBAL  = 2;
  localparam int SUM_FM2   = 1;
  localparam int SUM_FM1   = 0;
  localparam logic [15:0] SUM_USED = 16'h01bf;

  // interface error register bit positions
  localparam int IF_PECUP = 15;
  localparam int IF_PECDN = 14;
  localparam int IF_MANUP = 13;
  localparam int IF_MANDN = 12;
  localparam int IF_PARUP = 11;
  localparam int IF_PARDN = 10;
  localparam int IF_DUAL  = 9;
  localparam int IF_I2C   = 2;
  localparam int IF_RJCT  = 0;
  localparam logic [15:0] IF_W0C_MASK = 16'hfe01;
  localparam logic [15:0] IF_IFC_MASK = 16'h3e01;

  // source register fields
  localparam int SRC_CAL_LSB  = 0;
  localparam int SRC_AUX_LSB  = 8;
  // irq enable fields
  localparam int IRQ_CAL_LSB  = 0;
  localparam int IRQ_CB_LSB   = 8;
  localparam logic [15:0] IRQEN_RESET = 16'h1f1f;
  // balancing status fields
  localparam int CB_ALERT_LSB = 0;
  localparam int CB_STATE_LSB = 8;
  localparam int CB_TIMEOUT = 0;
  localparam int CB_TEMP    = 1;
  localparam int CB_CAL     = 2;
  localparam int CB_NOTIFY  = 3;
  localparam int CB_DONE    = 4;
  localparam int CTRL_START = 0;

  typedef enum logic [1:0] {
    CB_IDLE   = 2'b00,
    CB_ACTIVE = 2'b01,
    CB_FINISH = 2'b10,
    CB_FAULT  = 2'b11
  } als_cb_state_t;

  typedef struct packed {
    logic [AUX_N-1:0]  adcAuxOv;
    logic [AUX_N-1:0]  compAuxOv;
    logic [AUX_N-1:0]  adcAuxUv;
    logic [AUX_N-1:0]  compAuxUv;
    logic [AUX_N-1:0]  auxEnable;
    logic              acqDone;
    logic              pecUpErr;
    logic              pecDnErr;
    logic              manUpErr;
    logic              manDnErr;
    logic              parUpErr;
    logic              parDnErr;
    logic              dualFault;
    logic              rejectErr;
    logic              i2cAlert;
    logic              i2cEnable;
    logic [CAL_N-1:0]  calFault;
    logic              cbTimeout;
    logic              cbTemp;
    logic              cbNotify;
    logic              cbFinished;
    logic [DIAG_W-1:0] failDiagOne;
    logic [DIAG_W-1:0] failDiagTwo;
  } als_alerts_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } als_req_t;
endpackage : als_pkg
`default_nettype wire

// file: design/als_summary.sv
// Purpose: alert summary status bits 8..0 with their component alert registers
// Assumes: single 10 MHz clock, async active-high reset, synchronous inputs
// Notes:   read data valid the cycle after the read strobe; never stalls
//
// The register addresses and the strobed register port were decided locally.
`default_nettype none
module als_summary
#(
  parameter int AUX_N  = als_pkg::AUX_N,
  parameter int DIAG_W = als_pkg::DIAG_W
)
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire als_pkg::als_req_t          req,
  input  wire als_pkg::als_alerts_t       alerts,
  output logic [als_pkg::DATA_W-1:0]      rdata,
  output logic [als_pkg::DATA_W-1:0]      alertSummaryStatus,
  output logic [1:0]                      balancingActivityState,
  output logic                            balancingRun,
  output logic                            irq
);
  // carrier struct fixes the alert widths
  if (AUX_N != als_pkg::AUX_N || DIAG_W != als_pkg::DIAG_W)
  begin : g_bad_width
    $error("als_summary: alert widths are fixed by the carrier struct");
  end

  typedef struct packed {
    logic                        auxOv;
    logic                        auxUv;
    logic [3:0]                  srcAux;
    logic [15:0]                 ifErr;
    logic [als_pkg::CAL_N-1:0]   calFlt;
    logic [15:0]                 irqEn;
    logic [als_pkg::CB_N-1:0]    cbAlert;
    als_pkg::als_cb_state_t      cbState;
    logic [15:0]                 evt;
    logic [15:0]                 evtMask;
    logic [15:0]                 prevSum;
    logic [15:0]                 rdata;
  } als_state_t;

  als_state_t st;
  als_state_t next_st;

  logic [15:0] summary;
  logic [15:0] ifView;
  logic [15:0] srcView;
  logic [15:0] cbView;
  logic        anyOv;
  logic        anyUv;
  logic [3:0]  auxNow;
  logic        wrIf;
  logic        wrSrc;
  logic        wrCb;
  logic [15:0] ifSet;
  logic [als_pkg::CAL_N-1:0] calMask;
  logic [als_pkg::CB_N-1:0]  cbMask;
  logic [als_pkg::CB_N-1:0]  cbSet;

  always_comb
  begin
    // enabled aux conditions per path
    auxNow[0] = |(alerts.adcAuxOv  & alerts.auxEnable);
    auxNow[1] = |(alerts.compAuxOv & alerts.auxEnable);
    auxNow[2] = |(alerts.adcAuxUv  & alerts.auxEnable);
    auxNow[3] = |(alerts.compAuxUv & alerts.auxEnable);
    anyOv = auxNow[0] | auxNow[1];
    anyUv = auxNow[2] | auxNow[3];
    calMask = st.irqEn[als_pkg::IRQ_CAL_LSB +: als_pkg::CAL_N];
    cbMask  = st.irqEn[als_pkg::IRQ_CB_LSB +: als_pkg::CB_N];

    ifView = st.ifErr;
    ifView[als_pkg::IF_I2C] = alerts.i2cAlert & alerts.i2cEnable;

    summary = '0;
    summary[als_pkg::SUM_AUXOV] = st.auxOv;
    summary[als_pkg::SUM_AUXUV] = st.auxUv;
    summary[als_pkg::SUM_PEC] = st.ifErr[als_pkg::IF_PECUP]
                              | st.ifErr[als_pkg::IF_PECDN];
    // packet-check bits are outside the interface mask
    summary[als_pkg::SUM_IFC] = |(ifView & (als_pkg::IF_IFC_MASK
                              | (16'h0001 << als_pkg::IF_I2C)));
    summary[als_pkg::SUM_CAL]  = |(st.calFlt & calMask);
    summary[als_pkg::SUM_CBAL] = |(st.cbAlert & cbMask);
    summary[als_pkg::SUM_FM2]  = |alerts.failDiagTwo;
    summary[als_pkg::SUM_FM1]  = |alerts.failDiagOne;

    srcView = '0;
    srcView[als_pkg::SRC_CAL_LSB +: als_pkg::CAL_N] = st.calFlt;
    srcView[als_pkg::SRC_AUX_LSB +: 4] = st.srcAux;

    cbView = '0;
    cbView[als_pkg::CB_ALERT_LSB +: als_pkg::CB_N] = st.cbAlert;
    cbView[als_pkg::CB_STATE_LSB +: 2] = st.cbState;

    wrIf  = req.wr && req.addr == als_pkg::OFF_IFERR;
    wrSrc = req.wr && req.addr == als_pkg::OFF_SOURCE;
    wrCb  = req.wr && req.addr == als_pkg::OFF_CBSTAT;

    ifSet = '0;
    ifSet[als_pkg::IF_PECUP] = alerts.pecUpErr;
    ifSet[als_pkg::IF_PECDN] = alerts.pecDnErr;
    ifSet[als_pkg::IF_MANUP] = alerts.manUpErr;
    ifSet[als_pkg::IF_MANDN] = alerts.manDnErr;
    ifSet[als_pkg::IF_PARUP] = alerts.parUpErr;
    ifSet[als_pkg::IF_PARDN] = alerts.parDnErr;
    ifSet[als_pkg::IF_DUAL]  = alerts.dualFault;
    ifSet[als_pkg::IF_RJCT]  = alerts.rejectErr;

    next_st = st;

    // aux summaries latch until the next acquisition
    if (alerts.acqDone)
    begin
      next_st.auxOv  = anyOv;
      next_st.auxUv  = anyUv;
      next_st.srcAux = auxNow;
    end
    else
    begin
      next_st.auxOv  = st.auxOv | anyOv;
      next_st.auxUv  = st.auxUv | anyUv;
      next_st.srcAux = st.srcAux | auxNow;
    end

    // write 0 clears, write 1 ignored, new error wins
    next_st.ifErr = st.ifErr;
    if (wrIf)
      next_st.ifErr = st.ifErr & ~(~req.wdata & als_pkg::IF_W0C_MASK);
    next_st.ifErr = (next_st.ifErr | ifSet) & als_pkg::IF_W0C_MASK;

    next_st.calFlt = st.calFlt;
    if (wrSrc)
      next_st.calFlt = st.calFlt & req.wdata[als_pkg::SRC_CAL_LSB +: als_pkg::CAL_N];
    next_st.calFlt = next_st.calFlt | alerts.calFault;

    if (req.wr && req.addr == als_pkg::OFF_IRQEN)
      next_st.irqEn = req.wdata & als_pkg::IRQEN_RESET;

    // balancing sequencer
    cbSet = '0;
    cbSet[als_pkg::CB_TIMEOUT] = alerts.cbTimeout;
    cbSet[als_pkg::CB_TEMP]    = alerts.cbTemp;
    cbSet[als_pkg::CB_NOTIFY]  = alerts.cbNotify;
    case (st.cbState)
      als_pkg::CB_IDLE, als_pkg::CB_FINISH, als_pkg::CB_FAULT:
      begin
        if (req.wr && req.addr == als_pkg::OFF_CBCTRL
            && req.wdata[als_pkg::CTRL_START])
          next_st.cbState = als_pkg::CB_ACTIVE;
      end
      als_pkg::CB_ACTIVE:
      begin
        if (|alerts.calFault)
        begin
          next_st.cbState = als_pkg::CB_FAULT;
          cbSet[als_pkg::CB_CAL] = 1'b1;
        end
        else if (alerts.cbFinished)
        begin
          next_st.cbState = als_pkg::CB_FINISH;
          cbSet[als_pkg::CB_DONE] = 1'b1;
        end
      end
      default:
        next_st.cbState = als_pkg::CB_IDLE;
    endcase

    next_st.cbAlert = st.cbAlert;
    if (wrCb)
      next_st.cbAlert = st.cbAlert & req.wdata[als_pkg::CB_ALERT_LSB +: als_pkg::CB_N];
    next_st.cbAlert = next_st.cbAlert | cbSet;

    // summary rising edges feed the event register, write 1 clears
    next_st.prevSum = summary;
    next_st.evt = st.evt;
    if (req.wr && req.addr == als_pkg::OFF_EVENT)
      next_st.evt = st.evt & ~req.wdata;
    next_st.evt = (next_st.evt | (summary & ~st.prevSum)) & als_pkg::SUM_USED;
    if (req.wr && req.addr == als_pkg::OFF_EVMASK)
      next_st.evtMask = req.wdata & als_pkg::SUM_USED;

    // writes to OFF_SUMMARY fall through: derived bits only
    next_st.rdata = st.rdata;
    if (req.rd)
    begin
      case (req.addr)
        als_pkg::OFF_SUMMARY: next_st.rdata = summary;
        als_pkg::OFF_IFERR:   next_st.rdata = ifView;
        als_pkg::OFF_SOURCE:  next_st.rdata = srcView;
        als_pkg::OFF_IRQEN:   next_st.rdata = st.irqEn;
        als_pkg::OFF_CBSTAT:  next_st.rdata = cbView;
        als_pkg::OFF_EVENT:   next_st.rdata = st.evt;
        als_pkg::OFF_EVMASK:  next_st.rdata = st.evtMask;
        default:              next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st         <= '0;
      st.irqEn   <= als_pkg::IRQEN_RESET;
      st.cbState <= als_pkg::CB_IDLE;
    end
    else
      st <= next_st;
  end

  assign rdata                  = st.rdata;
  assign alertSummaryStatus     = summary;
  assign balancingActivityState = st.cbState;
  assign balancingRun           = st.cbState == als_pkg::CB_ACTIVE;
  assign irq                    = |(st.evt & st.evtMask);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence calHitWhileActive;
    st.cbState == als_pkg::CB_ACTIVE && |alerts.calFault;
  endsequence
  sequence faultRecorded;
    st.cbState == als_pkg::CB_FAULT && st.cbAlert[als_pkg::CB_CAL];
  endsequence
  sequence doneWhileActive;
    st.cbState == als_pkg::CB_ACTIVE && alerts.cbFinished && !(|alerts.calFault);
  endsequence
  sequence doneRecorded;
    st.cbState == als_pkg::CB_FINISH && st.cbAlert[als_pkg::CB_DONE];
  endsequence

  chk_aux_ov_sets: assert property (
    anyOv |=> alertSummaryStatus[als_pkg::SUM_AUXOV])
    else $error("aux overvoltage summary missed");
  chk_aux_uv_holds: assert property (
    alertSummaryStatus[als_pkg::SUM_AUXUV] && !alerts.acqDone
    |=> alertSummaryStatus[als_pkg::SUM_AUXUV])
    else $error("aux undervoltage summary dropped before acquisition");
  chk_aux_clear_acq: assert property (
    alerts.acqDone && !anyOv |=> !alertSummaryStatus[als_pkg::SUM_AUXOV])
    else $error("aux overvoltage summary kept after resolved acquisition");
  chk_source_comp: assert property (
    auxNow[1] |=> st.srcAux[1])
    else $error("comparator aux source not recorded");
  chk_pec_pair: assert property (
    alerts.pecUpErr || alerts.pecDnErr |=> alertSummaryStatus[als_pkg::SUM_PEC])
    else $error("packet-check summary missed");
  chk_pec_not_ifc: assert property (
    alerts.pecUpErr && st.ifErr == '0 && !ifView[als_pkg::IF_I2C]
    && !(|ifSet[als_pkg::IF_MANUP:als_pkg::IF_DUAL]) && !alerts.rejectErr
    |=> !alertSummaryStatus[als_pkg::SUM_IFC] ##0 alertSummaryStatus[als_pkg::SUM_PEC])
    else $error("packet-check error raised interface summary");
  chk_pec_write1: assert property (
    st.ifErr[als_pkg::IF_PECUP] && wrIf && req.wdata[als_pkg::IF_PECUP]
    |=> st.ifErr[als_pkg::IF_PECUP])
    else $error("writing 1 cleared packet-check alert");
  chk_cal_abort: assert property (
    calHitWhileActive |=> faultRecorded ##0 !balancingRun)
    else $error("calibration fault did not end balancing");
  chk_cbal_sum: assert property (
    st.cbAlert[als_pkg::CB_DONE] && cbMask[als_pkg::CB_DONE]
    |-> alertSummaryStatus[als_pkg::SUM_CBAL])
    else $error("balancing summary missed done alert");
  chk_fm_or: assert property (
    (|alerts.failDiagOne) == alertSummaryStatus[als_pkg::SUM_FM1])
    else $error("failure diagnostic one summary mismatch");
  chk_sum_write: assert property (
    req.wr && req.addr == als_pkg::OFF_SUMMARY && !anyOv && !alerts.acqDone
    && alertSummaryStatus[als_pkg::SUM_AUXOV]
    |=> alertSummaryStatus[als_pkg::SUM_AUXOV])
    else $error("summary write changed aux summary");
  chk_cal_clear: assert property (
    $fell(alertSummaryStatus[als_pkg::SUM_CAL])
    |-> (st.calFlt & calMask) == '0)
    else $error("calibration summary cleared with masked alert pending");

  // aux summaries and their sources
  chk_aux_uv_sets: assert property (
    anyUv |=> alertSummaryStatus[als_pkg::SUM_AUXUV])
    else $error("aux undervoltage summary missed");
  chk_aux_ov_holds: assert property (
    alertSummaryStatus[als_pkg::SUM_AUXOV] && !alerts.acqDone
    |=> alertSummaryStatus[als_pkg::SUM_AUXOV])
    else $error("aux overvoltage summary dropped before acquisition");
  chk_aux_uv_clear: assert property (
    alerts.acqDone && !anyUv |=> !alertSummaryStatus[als_pkg::SUM_AUXUV])
    else $error("aux undervoltage summary kept after resolved acquisition");
  chk_source_adc: assert property (
    auxNow[0] |=> st.srcAux[0])
    else $error("adc aux overvoltage source not recorded");
  chk_source_adc_uv: assert property (
    auxNow[2] |=> st.srcAux[2])
    else $error("adc aux undervoltage source not recorded");
  chk_source_comp_uv: assert property (
    auxNow[3] |=> st.srcAux[3])
    else $error("comparator aux undervoltage source not recorded");
  chk_source_acq: assert property (
    alerts.acqDone |=> st.srcAux == $past(auxNow))
    else $error("aux source not reloaded at acquisition");

  // packet-check and interface errors
  chk_pec_hold: assert property (
    alertSummaryStatus[als_pkg::SUM_PEC] && !wrIf
    |=> alertSummaryStatus[als_pkg::SUM_PEC])
    else $error("packet-check summary dropped without a clear");
  chk_pec_clear: assert property (
    wrIf && !alerts.pecUpErr && !alerts.pecDnErr
    && !(st.ifErr[als_pkg::IF_PECUP] && req.wdata[als_pkg::IF_PECUP])
    && !(st.ifErr[als_pkg::IF_PECDN] && req.wdata[als_pkg::IF_PECDN])
    |=> !alertSummaryStatus[als_pkg::SUM_PEC])
    else $error("packet-check summary kept after both alerts cleared");
  chk_ifc_sets: assert property (
    |ifSet[als_pkg::IF_MANUP:als_pkg::IF_DUAL] || alerts.rejectErr
    |=> alertSummaryStatus[als_pkg::SUM_IFC])
    else $error("interface summary missed a link error");
  chk_ifc_i2c: assert property (
    alerts.i2cAlert && alerts.i2cEnable |-> alertSummaryStatus[als_pkg::SUM_IFC])
    else $error("interface summary missed i2c alert");
  chk_ifc_i2c_off: assert property (
    !alerts.i2cEnable && (st.ifErr & als_pkg::IF_IFC_MASK) == '0
    |-> !alertSummaryStatus[als_pkg::SUM_IFC])
    else $error("interface summary set by disabled i2c alert");
  chk_pecdn_write1: assert property (
    st.ifErr[als_pkg::IF_PECDN] && wrIf && req.wdata[als_pkg::IF_PECDN]
    |=> st.ifErr[als_pkg::IF_PECDN])
    else $error("writing 1 cleared downstream packet-check alert");

  // calibration and balancing
  chk_cal_sets: assert property (
    |(alerts.calFault & calMask) && !(req.wr && req.addr == als_pkg::OFF_IRQEN)
    |=> alertSummaryStatus[als_pkg::SUM_CAL])
    else $error("calibration summary missed an alert");
  chk_cal_sticky: assert property (
    !wrSrc |=> (st.calFlt & $past(st.calFlt)) == $past(st.calFlt))
    else $error("calibration alert dropped without a clear");
  chk_fault_holds: assert property (
    st.cbState == als_pkg::CB_FAULT && !(req.wr && req.addr == als_pkg::OFF_CBCTRL)
    |=> st.cbState == als_pkg::CB_FAULT)
    else $error("balancing fault state left without a restart");
  chk_cb_done: assert property (
    doneWhileActive |=> doneRecorded)
    else $error("balancing completion not recorded");
  chk_cbal_cal: assert property (
    st.cbAlert[als_pkg::CB_CAL] && cbMask[als_pkg::CB_CAL]
    |-> alertSummaryStatus[als_pkg::SUM_CBAL])
    else $error("balancing summary missed calibration alert");
  chk_cb_sticky: assert property (
    !wrCb |=> (st.cbAlert & $past(st.cbAlert)) == $past(st.cbAlert))
    else $error("balancing alert dropped without a clear");

  // failure diagnostics and host access
  chk_fm2_or: assert property (
    (|alerts.failDiagTwo) == alertSummaryStatus[als_pkg::SUM_FM2])
    else $error("failure diagnostic two summary mismatch");
  chk_rd_summary: assert property (
    req.rd && req.addr == als_pkg::OFF_SUMMARY |=> rdata == $past(alertSummaryStatus))
    else $error("summary read returned wrong word");
endmodule : als_summary
`default_nettype wire

// file: tb/als_summary_tb_top.sv
// Purpose: self-checking bench for the alert summary status block
// Assumes: register port with read data in the cycle after the strobe
// Notes:   inputs change by nba at rising edges, outputs sampled at falling edges
`default_nettype none
module als_summary_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                      clk = 1'b0;
  logic                      reset = 1'b1;
  als_pkg::als_req_t         req = '0;
  als_pkg::als_alerts_t      alerts = '0;
  logic [15:0]               rdata;
  logic [15:0]               alertSummaryStatus;
  logic [1:0]                balancingActivityState;
  logic                      balancingRun;
  logic                      irq;
  int                        error_cnt = 0;
  int                        total_checks = 0;
  als_pkg::als_alerts_t      p;
  logic [15:0]               d;

  always #50 clk = ~clk;

  als_summary i_als_summary (.clk(clk), .reset(reset), .req(req), .alerts(alerts),
    .rdata(rdata), .alertSummaryStatus(alertSummaryStatus),
    .balancingActivityState(balancingActivityState), .balancingRun(balancingRun), .irq(irq));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic sum(input logic [15:0] exp);
    chk(alertSummaryStatus & als_pkg::SUM_USED, exp);
  endtask : sum

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : rd

  task automatic pulse(input als_pkg::als_alerts_t m);
    @(posedge clk);
    alerts <= alerts | m;
    @(posedge clk);
    alerts <= alerts & ~m;
    @(negedge clk);
  endtask : pulse

  task automatic test_aux;
    @(posedge clk);
    alerts.auxEnable <= 6'h3e;
    alerts.adcAuxOv <= 6'h01;
    @(negedge clk);
    @(negedge clk);
    sum(16'h0000);
    @(posedge clk);
    alerts.auxEnable <= 6'h3f;
    alerts.compAuxOv <= 6'h20;
    @(negedge clk);
    @(negedge clk);
    sum(16'h0100);
    rd(als_pkg::OFF_SOURCE, 16'h0300);
    @(posedge clk);
    alerts.adcAuxOv <= 6'h00;
    alerts.compAuxOv <= 6'h00;
    alerts.compAuxUv <= 6'h04;
    @(negedge clk);
    @(negedge clk);
    sum(16'h0180);
    wr(als_pkg::OFF_SUMMARY, 16'h0000);
    sum(16'h0180);
    // source bits gather every path seen since the last acquisition
    rd(als_pkg::OFF_SOURCE, 16'h0b00);
    p = '0;
    p.acqDone = 1'b1;
    pulse(p);
    sum(16'h0080);
    rd(als_pkg::OFF_SOURCE, 16'h0800);
    @(posedge clk);
    alerts.compAuxUv <= 6'h00;
    @(negedge clk);
    sum(16'h0080);
    pulse(p);
    sum(16'h0000);
    $display("test aux done");
  endtask : test_aux

  task automatic test_pec;
    p = '0;
    p.pecUpErr = 1'b1;
    p.pecDnErr = 1'b1;
    pulse(p);
    sum(16'h0020);
    wr(als_pkg::OFF_IFERR, 16'hffff);
    rd(als_pkg::OFF_IFERR, 16'hc000);
    wr(als_pkg::OFF_IFERR, 16'h7fff);
    sum(16'h0020);
    wr(als_pkg::OFF_IFERR, 16'hbfff);
    sum(16'h0000);
    $display("test pec done");
  endtask : test_pec

  task automatic test_intf;
    for (int i = 0; i < 7; i++)
    begin
      p = '0;
      {p.manUpErr, p.manDnErr, p.parUpErr, p.parDnErr, p.dualFault, p.rejectErr} = 6'h20 >> i;
      d = (i < 6) ? (16'h2000 >> i) : 16'h0000;
      if (i == 5)
        d = 16'h0001;
      pulse(p);
      sum((i < 6) ? 16'h0010 : 16'h0000);
      rd(als_pkg::OFF_IFERR, d);
      wr(als_pkg::OFF_IFERR, ~d);
      sum(16'h0000);
    end
    @(posedge clk);
    alerts.i2cAlert <= 1'b1;
    @(negedge clk);
    sum(16'h0000);
    @(posedge clk);
    alerts.i2cEnable <= 1'b1;
    @(negedge clk);
    sum(16'h0010);
    @(posedge clk);
    alerts.i2cAlert <= 1'b0;
    @(negedge clk);
    sum(16'h0000);
    $display("test intf done");
  endtask : test_intf

  task automatic test_cal;
    for (int i = 0; i < 5; i++)
    begin
      p = '0;
      p.calFault = 5'h01 << i;
      pulse(p);
      sum(16'h0008);
      rd(als_pkg::OFF_SOURCE, 16'h0001 << i);
      wr(als_pkg::OFF_SOURCE, 16'h0000);
      sum(16'h0000);
    end
    wr(als_pkg::OFF_IRQEN, 16'h1f00);
    p.calFault = 5'h1f;
    pulse(p);
    sum(16'h0000);
    wr(als_pkg::OFF_SOURCE, 16'h0000);
    wr(als_pkg::OFF_IRQEN, als_pkg::IRQEN_RESET);
    $display("test cal done");
  endtask : test_cal

  task automatic test_cb;
    wr(als_pkg::OFF_CBCTRL, 16'h0001);
    chk({14'h0, balancingActivityState}, 16'h0001);
    chk({15'h0, balancingRun}, 16'h0001);
    sum(16'h0000);
    p = '0;
    p.calFault = 5'h04;
    pulse(p);
    @(negedge clk);
    chk({14'h0, balancingActivityState}, 16'h0003);
    chk({15'h0, balancingRun}, 16'h0000);
    sum(16'h000c);
    rd(als_pkg::OFF_CBSTAT, 16'h0304);
    wr(als_pkg::OFF_CBSTAT, 16'h0000);
    wr(als_pkg::OFF_SOURCE, 16'h0000);
    sum(16'h0000);
    wr(als_pkg::OFF_CBCTRL, 16'h0001);
    p = '0;
    p.cbFinished = 1'b1;
    pulse(p);
    @(negedge clk);
    chk({14'h0, balancingActivityState}, 16'h0002);
    sum(16'h0004);
    wr(als_pkg::OFF_IRQEN, 16'h001f);
    sum(16'h0000);
    wr(als_pkg::OFF_IRQEN, als_pkg::IRQEN_RESET);
    wr(als_pkg::OFF_CBSTAT, 16'h0000);
    sum(16'h0000);
    $display("test cb done");
  endtask : test_cb

  task automatic test_fm;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      alerts.failDiagOne <= 16'h0001 << i;
      alerts.failDiagTwo <= 16'h8000 >> i;
      @(negedge clk);
      sum(16'h0003);
      wr(als_pkg::OFF_SUMMARY, 16'h0000);
      rd(als_pkg::OFF_SUMMARY, 16'h0003);
      @(posedge clk);
      alerts.failDiagTwo <= 16'h0000;
      @(negedge clk);
      sum(16'h0001);
    end
    @(posedge clk);
    alerts.failDiagOne <= 16'h0000;
    @(negedge clk);
    sum(16'h0000);
    $display("test fm done");
  endtask : test_fm

  task automatic test_irq;
    rd(als_pkg::OFF_IRQEN, als_pkg::IRQEN_RESET);
    rd(als_pkg::OFF_EVMASK, 16'h0000);
    rd(4'h9, 16'h0000);
    wr(als_pkg::OFF_EVENT, 16'hffff);
    wr(als_pkg::OFF_EVMASK, 16'h0001);
    @(posedge clk);
    alerts.failDiagOne <= 16'h0010;
    repeat (3) @(negedge clk);
    chk({15'h0, irq}, 16'h0001);
    rd(als_pkg::OFF_EVENT, 16'h0001);
    @(posedge clk);
    alerts.failDiagOne <= 16'h0000;
    wr(als_pkg::OFF_EVENT, 16'h0001);
    repeat (2) @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    wr(als_pkg::OFF_EVMASK, 16'h0000);
    @(posedge clk);
    alerts.failDiagOne <= 16'h0010;
    repeat (3) @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    @(posedge clk);
    alerts.failDiagOne <= 16'h0000;
    wr(als_pkg::OFF_EVENT, 16'hffff);
    $display("test irq done");
  endtask : test_irq

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    #2000000;
    error_cnt++;
    finish_test();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    test_irq();
    test_aux();
    test_pec();
    test_intf();
    test_cal();
    test_cb();
    test_fm();
    finish_test();
  end
endmodule : als_summary_tb_top
`default_nettype wire
